// ### core/dcs_consts.vh
/*
 * Constants of the two-channel serial controller: port addresses,
 * command codes, register pointers, field positions and reset values.
 * Assumes it is included once per design file by its bare name.
 */
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH

// Host-visible port addresses
`define DCS_ADDR_CH0_DATA 24'hc21001
`define DCS_ADDR_CH1_DATA 24'hc21003
`define DCS_ADDR_CH0_CTRL 24'hc21005
`define DCS_ADDR_CH1_CTRL 24'hc21007

// Command register fields and codes
`define DCS_WR0_CMD 5:3
`define DCS_WR0_PTR 2:0
`define DCS_CMD_NULL 3'h0
`define DCS_CMD_EXT_RESET 3'h2
`define DCS_CMD_CHAN_RESET 3'h3
`define DCS_CMD_REARM_RX 3'h4
`define DCS_CMD_TX_INT_CLR 3'h5
`define DCS_CMD_ERR_RESET 3'h6
`define DCS_CMD_RETI 3'h7

// Pointer values
`define DCS_REG_0 3'h0
`define DCS_REG_1 3'h1
`define DCS_REG_2 3'h2
`define DCS_REG_3 3'h3
`define DCS_REG_4 3'h4
`define DCS_REG_5 3'h5

// Interrupt setup fields
`define DCS_WR1_RXMODE 4:3
`define DCS_WR1_SAV 2
`define DCS_WR1_TXIE 1
`define DCS_WR1_EXTIE 0
`define DCS_RXI_OFF 2'h0
`define DCS_RXI_FIRST 2'h1
`define DCS_RXI_ALL_PAR 2'h2
`define DCS_RXI_ALL 2'h3

// Receive, clock and transmit setup fields
`define DCS_WR3_LEN 7:6
`define DCS_WR3_AUTO 5
`define DCS_WR3_RXEN 0
`define DCS_WR4_CLK 7:6
`define DCS_WR4_PEV 1
`define DCS_WR4_PEN 0
`define DCS_WR5_DTR 7
`define DCS_WR5_LEN 6:5
`define DCS_WR5_BRK 4
`define DCS_WR5_TXEN 3
`define DCS_WR5_RTS 1

// Status bit positions
`define DCS_RR0_BRK 7
`define DCS_RR0_CTS 5
`define DCS_RR0_DCD 3
`define DCS_RR0_TBE 2
`define DCS_RR0_IP 1
`define DCS_RR0_RCA 0
`define DCS_RR1_ERR 6:4
`define DCS_RR1_SENT 0

// Interrupt source index inside a channel
`define DCS_SRC_TX 2'h0
`define DCS_SRC_EXT 2'h1
`define DCS_SRC_RX 2'h2
`define DCS_SRC_SP 2'h3

// Sizes, divisors, lengths and reset values
`define DCS_RXQ_DEPTH 3
`define DCS_RXQ_AW 2
`define DCS_TXQ_DEPTH 2
`define DCS_TXQ_AW 1
`define DCS_DIV_1 7'd1
`define DCS_DIV_16 7'd16
`define DCS_DIV_32 7'd32
`define DCS_DIV_64 7'd64
`define DCS_LEN_5 4'h5
`define DCS_LEN_6 4'h6
`define DCS_LEN_7 4'h7
`define DCS_LEN_8 4'h8
`define DCS_RST_BYTE 8'h00
`define DCS_MARK 1'b1

`endif

// ### core/dcs_serial.v
/*
 * Two-channel serial controller: byte ports for host, per-channel
 * pointer/command registers, transmitter, receiver, modem lines and
 * vectored interrupt request; plus the small FIFO used as char_queue.
 * Assumes a host bus on the same clock with one-cycle read and write
 * strobes, and bit clocks, data and modem inputs arriving on pins.
 */
// Behaviour
// R1: Pointer field selects next accessed register
// R2: Command field decodes seven documented actions
// R3: External status latched until reset command
// R4: External reset also clears status interrupt
// R5: First-character mode waits for rearm command
// R6: Transmit empty interrupt, clearable by command
// R7: Framing, overrun, parity errors latch until reset
// R8: Return command clears serviced interrupt, channel 0
// R9: Receive interrupt mode field selects behaviour
// R10: Status-modifies-vector rewrites vector bits three-one
// R11: Enables for transmit and modem-change interrupts
// R12: Channel 1 holds and returns base vector; reads return vec_c, with bits three-one modified under R10
// R13: Receive length codes give 5,7,6,8 bits
// R14: Modem-gated flow gates receive and transmit
// R15: Receiver enable bit; software zeros reserved bits
// R16: Clock mode divides bit clock 1,16,32,64
// R17: Terminal-ready and request-to-send follow setup bits
// R18: Transmit length codes give 5,7,6,8 bits
// R19: Break holds line low; enable gates transmit
// R20: Break, clear-to-send, carrier-detect status bits
// R21: Buffer-free, pending and character-ready status
// R22: All-sent only after shifter fully drained
// R23: Vector code per channel and source
// R24: Three-character receive queue, overrun when full
// R25: Pointer returns to zero after access
// R26: Channels independent except shared vector settings

`include "dcs_consts.vh"

module dcs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and resets
  input wire clock,
  input wire resetn,
  input wire flush,
  // Filling side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // Draining side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  localparam integer LAST_I = DEPTH - 1;
  localparam [AW:0] FULL = DEPTH[AW:0];
  localparam [AW-1:0] LAST = LAST_I[AW-1:0];
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Honest flags straight from the fill count
  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];

  // Pointers wrap at DEPTH, which need not be a power of two
  always @(posedge clock) begin
    if (!resetn || flush) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= (wp_r == LAST) ? {AW{1'b0}} : wp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
        rp_r <= (rp_r == LAST) ? {AW{1'b0}} : rp_r + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // dcs_fifo

module dcs_serial (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Host byte bus
  input wire [23:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata_r,
  // Interrupt request and vector
  output reg irq_n_r,
  output reg [7:0] int_vector_r,
  // Serial pins, index is channel
  input wire [1:0] bclk,
  input wire [1:0] rxd,
  input wire [1:0] cts_n,
  input wire [1:0] dcd_n,
  output wire [1:0] txd,
  output wire [1:0] rts_n,
  output wire [1:0] dtr_n
);
  localparam TX_IDLE = 1'b0;
  localparam TX_SHIFT = 1'b1;
  localparam RX_IDLE = 1'b0;
  localparam RX_RUN = 1'b1;

  // Port decode: {hit, control, channel}
  function [2:0] port_sel;
    input [23:0] a;
    begin
      if (a == `DCS_ADDR_CH0_DATA) port_sel = 3'h4;
      else if (a == `DCS_ADDR_CH1_DATA) port_sel = 3'h5;
      else if (a == `DCS_ADDR_CH0_CTRL) port_sel = 3'h6;
      else if (a == `DCS_ADDR_CH1_CTRL) port_sel = 3'h7;
      else port_sel = 3'h0;
    end
  endfunction

  // R13: length code decode
  function [3:0] char_len;
    input [1:0] code;
    begin
      case (code)
        2'h0: char_len = `DCS_LEN_5;
        2'h1: char_len = `DCS_LEN_7;
        2'h2: char_len = `DCS_LEN_6;
        default: char_len = `DCS_LEN_8;
      endcase
    end
  endfunction

  // R16: bit clock ticks per bit
  function [6:0] div_ticks;
    input [1:0] mode;
    begin
      case (mode)
        2'h0: div_ticks = `DCS_DIV_1;
        2'h1: div_ticks = `DCS_DIV_16;
        2'h2: div_ticks = `DCS_DIV_32;
        default: div_ticks = `DCS_DIV_64;
      endcase
    end
  endfunction

  // Frame LSB first: start, data, optional parity, stop fill
  function [10:0] tx_frame;
    input [7:0] d;
    input [3:0] len;
    input pen;
    input pbit;
    integer i;
    begin
      tx_frame = {11{`DCS_MARK}};
      tx_frame[0] = 1'b0;
      for (i = 0; i < 8; i = i + 1)
        if (i < len) tx_frame[i+1] = d[i];
      if (pen) tx_frame[len+1] = pbit;
    end
  endfunction

  // Highest pending source: channel 0 first, special, rx, tx, ext
  function [3:0] pick_src;
    input [7:0] ip;
    begin
      if (ip[3]) pick_src = {1'b1, 1'b1, `DCS_SRC_SP};
      else if (ip[2]) pick_src = {1'b1, 1'b1, `DCS_SRC_RX};
      else if (ip[0]) pick_src = {1'b1, 1'b1, `DCS_SRC_TX};
      else if (ip[1]) pick_src = {1'b1, 1'b1, `DCS_SRC_EXT};
      else if (ip[7]) pick_src = {1'b1, 1'b0, `DCS_SRC_SP};
      else if (ip[6]) pick_src = {1'b1, 1'b0, `DCS_SRC_RX};
      else if (ip[4]) pick_src = {1'b1, 1'b0, `DCS_SRC_TX};
      else if (ip[5]) pick_src = {1'b1, 1'b0, `DCS_SRC_EXT};
      else pick_src = 4'h0;
    end
  endfunction

  wire [5:0] ptr_w;
  wire [15:0] rr0_w;
  wire [15:0] rr1_w;
  wire [15:0] rxh_w;
  wire [7:0] ip_w;
  wire [1:0] sav_w;
  reg [7:0] base_r;
  reg [7:0] vec_c;
  wire [2:0] wsel = port_sel(bus_addr);
  wire [3:0] pick = pick_src(ip_w);
  wire [2:0] pick_idx = {~pick[2], pick[1:0]};
  // R8: return command exists on channel 0 only
  wire reti_go = bus_wr & (wsel == 3'h6) & (ptr_w[2:0] == `DCS_REG_0) &
    (bus_wdata[`DCS_WR0_CMD] == `DCS_CMD_RETI);
  wire [7:0] reti_clr = (reti_go & pick[3]) ? (8'h01 << pick_idx) : 8'h00;

  // R10: modify bits three-one when enabled; R23: source code
  always @* begin
    vec_c = base_r;
    if (sav_w[1] && pick[3])
      vec_c = {base_r[7:4], pick[2:0], base_r[0]};
  end

  // R12: base vector lives in channel 1 only
  always @(posedge clock) begin
    if (!resetn)
      base_r <= `DCS_RST_BYTE;
    else if (bus_wr && wsel == 3'h7 && ptr_w[5:3] == `DCS_REG_2)
      base_r <= bus_wdata;
  end

  // Request and vector outputs registered
  always @(posedge clock) begin
    if (!resetn) begin
      irq_n_r <= 1'b1;
      int_vector_r <= `DCS_RST_BYTE;
    end else begin
      irq_n_r <= ~(|ip_w);
      int_vector_r <= vec_c;
    end
  end

  // Read mux; unmapped addresses and absent registers read zero
  always @(posedge clock) begin
    if (!resetn)
      bus_rdata_r <= `DCS_RST_BYTE;
    else if (bus_rd) begin
      if (wsel == 3'h4)
        bus_rdata_r <= rxh_w[7:0];
      else if (wsel == 3'h5)
        bus_rdata_r <= rxh_w[15:8];
      else if (wsel[2:1] == 2'h3) begin
        // R1: pointer picks the read register
        if ((wsel[0] ? ptr_w[5:3] : ptr_w[2:0]) == `DCS_REG_0)
          bus_rdata_r <= wsel[0] ? rr0_w[15:8] : (rr0_w[7:0] |
            ({7'h0, |ip_w} << `DCS_RR0_IP));
        else if ((wsel[0] ? ptr_w[5:3] : ptr_w[2:0]) == `DCS_REG_1)
          bus_rdata_r <= wsel[0] ? rr1_w[15:8] : rr1_w[7:0];
        else if ((wsel[0] ? ptr_w[5:3] : ptr_w[2:0]) == `DCS_REG_2)
          bus_rdata_r <= wsel[0] ? vec_c : `DCS_RST_BYTE;
        else
          bus_rdata_r <= `DCS_RST_BYTE;
      end else
        bus_rdata_r <= `DCS_RST_BYTE;
    end
  end

  // R26: one independent copy of the channel logic each
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gen_ch
      localparam [0:0] CH = (gi == 1);
      reg [2:0] rx_s;
      reg [2:0] cts_s;
      reg [2:0] dcd_s;
      reg [2:0] bck_s;
      reg [2:0] ptr_r;
      reg [7:0] wr1_r;
      reg [7:0] wr3_r;
      reg [7:0] wr4_r;
      reg [7:0] wr5_r;
      reg tx_st_r;
      reg [10:0] tsh_r;
      reg [3:0] tleft_r;
      reg [6:0] tdiv_r;
      reg txd_r;
      reg rts_n_r;
      reg dtr_n_r;
      reg tx_av_q;
      reg rx_st_r;
      reg [6:0] rdiv_r;
      reg [3:0] ridx_r;
      reg [7:0] rsh_r;
      reg rpar_r;
      reg rstop_r;
      reg rx_fin_r;
      reg brk_live_r;
      reg [2:0] err_r;
      reg [2:0] ref_r;
      reg [2:0] shown_r;
      reg elat_r;
      reg [3:0] ip_r;
      reg arm_r;
      reg [7:0] rr0_c;
      wire tx_rdy;
      wire tx_av;
      wire [7:0] tx_d;
      wire rx_rdy;
      wire rx_av;
      wire [7:0] rx_head;

      // Second stage feeds logic, third stage only the bit clock edge; first stage feeds the second alone
      always @(posedge clock) begin
        if (!resetn) begin
          rx_s <= 3'h7;
          cts_s <= 3'h7;
          dcd_s <= 3'h7;
          bck_s <= 3'h0;
        end else begin
          rx_s <= {rx_s[1:0], rxd[gi]};
          cts_s <= {cts_s[1:0], cts_n[gi]};
          dcd_s <= {dcd_s[1:0], dcd_n[gi]};
          bck_s <= {bck_s[1:0], bclk[gi]};
        end
      end

      wire tick = bck_s[1] & ~bck_s[2];
      wire rx_line = rx_s[1];
      wire cts_on = ~cts_s[1];
      wire dcd_on = ~dcd_s[1];
      wire ctl_wr = bus_wr & (wsel == {2'h3, CH});
      wire ctl_rd = bus_rd & (wsel == {2'h3, CH});
      wire dat_wr = bus_wr & (wsel == {2'h2, CH});
      wire dat_rd = bus_rd & (wsel == {2'h2, CH});
      wire cmd_go = ctl_wr & (ptr_r == `DCS_REG_0);
      wire [2:0] cmd = bus_wdata[`DCS_WR0_CMD];
      // R2: command decode, other codes do nothing
      wire chan_rst = cmd_go & (cmd == `DCS_CMD_CHAN_RESET);
      wire ext_rst = cmd_go & (cmd == `DCS_CMD_EXT_RESET);
      wire rearm = cmd_go & (cmd == `DCS_CMD_REARM_RX);
      wire txi_clr = cmd_go & (cmd == `DCS_CMD_TX_INT_CLR);
      wire err_rst = cmd_go & (cmd == `DCS_CMD_ERR_RESET);
      wire [6:0] nper = div_ticks(wr4_r[`DCS_WR4_CLK]);
      wire pen = wr4_r[`DCS_WR4_PEN];
      wire pev = wr4_r[`DCS_WR4_PEV];
      wire [1:0] rmode = wr1_r[`DCS_WR1_RXMODE];

      // R1: pointer and write registers; R25: back to zero after use
      always @(posedge clock) begin
        if (!resetn || chan_rst) begin
          ptr_r <= `DCS_REG_0;
          wr1_r <= `DCS_RST_BYTE;
          wr3_r <= `DCS_RST_BYTE;
          wr4_r <= `DCS_RST_BYTE;
          wr5_r <= `DCS_RST_BYTE;
        end else if (ctl_wr) begin
          if (ptr_r == `DCS_REG_0)
            ptr_r <= bus_wdata[`DCS_WR0_PTR];
          else begin
            ptr_r <= `DCS_REG_0;
            if (ptr_r == `DCS_REG_1)
              wr1_r <= bus_wdata;
            else if (ptr_r == `DCS_REG_3)
              wr3_r <= bus_wdata;
            else if (ptr_r == `DCS_REG_4)
              wr4_r <= bus_wdata;
            else if (ptr_r == `DCS_REG_5)
              wr5_r <= bus_wdata;
          end
        end else if (ctl_rd)
          ptr_r <= `DCS_REG_0;
      end

      // R18: transmit length; R14 and R19: gating of start
      wire [3:0] tlen = char_len(wr5_r[`DCS_WR5_LEN]);
      wire [7:0] tmask = 8'hff >> (4'h8 - tlen);
      wire tpar = (^(tx_d & tmask)) ^ ~pev;
      wire tx_start = (tx_st_r == TX_IDLE) & tx_av & wr5_r[`DCS_WR5_TXEN] &
        (~wr3_r[`DCS_WR3_AUTO] | cts_on);

      // Two-deep transmit buffer; a host write to a full buffer is dropped
      dcs_fifo #(.WIDTH(8), .DEPTH(`DCS_TXQ_DEPTH), .AW(`DCS_TXQ_AW)) u_txq (
        .clock(clock),
        .resetn(resetn),
        .flush(chan_rst),
        .in_valid(dat_wr),
        .in_data(bus_wdata),
        .in_ready(tx_rdy),
        .out_valid(tx_av),
        .out_data(tx_d),
        .out_ready(tx_start)
      );

      // Transmitter; a buffered character waits while disabled
      always @(posedge clock) begin
        if (!resetn || chan_rst) begin
          tx_st_r <= TX_IDLE;
          tsh_r <= {11{`DCS_MARK}};
          tleft_r <= 4'h0;
          tdiv_r <= 7'h0;
          txd_r <= `DCS_MARK;
        end else begin
          case (tx_st_r)
            TX_IDLE: if (tx_start) begin
              tsh_r <= tx_frame(tx_d, tlen, pen, tpar);
              tleft_r <= tlen + 4'h2 + {3'h0, pen};
              tdiv_r <= 7'h0;
              tx_st_r <= TX_SHIFT;
            end
            default: if (tick) begin
              if (tdiv_r == nper - 7'h1) begin
                tdiv_r <= 7'h0;
                tsh_r <= {`DCS_MARK, tsh_r[10:1]};
                tleft_r <= tleft_r - 4'h1;
                if (tleft_r == 4'h1)
                  tx_st_r <= TX_IDLE;
              end else
                tdiv_r <= tdiv_r + 7'h1;
            end
          endcase
          // R19: break overrides everything on the line
          txd_r <= wr5_r[`DCS_WR5_BRK] ? 1'b0 :
            ((tx_st_r == TX_SHIFT) ? tsh_r[0] : `DCS_MARK);
        end
      end

      // R17: modem outputs follow setup bits, active low pins
      always @(posedge clock) begin
        if (!resetn) begin
          rts_n_r <= 1'b1;
          dtr_n_r <= 1'b1;
        end else begin
          rts_n_r <= ~wr5_r[`DCS_WR5_RTS];
          dtr_n_r <= ~wr5_r[`DCS_WR5_DTR];
        end
      end

      // R13, R15, R14: receive length, enable and carrier gating
      wire [3:0] rlen = char_len(wr3_r[`DCS_WR3_LEN]);
      wire [3:0] rlast = rlen + 4'h1 + {3'h0, pen};
      wire rx_ok = wr3_r[`DCS_WR3_RXEN] & ~brk_live_r &
        (~wr3_r[`DCS_WR3_AUTO] | dcd_on);

      // Receiver: start found on a tick, each bit sampled mid-cell
      always @(posedge clock) begin
        if (!resetn || chan_rst) begin
          rx_st_r <= RX_IDLE;
          rdiv_r <= 7'h0;
          ridx_r <= 4'h0;
          rsh_r <= 8'h00;
          rpar_r <= 1'b0;
          rstop_r <= `DCS_MARK;
          rx_fin_r <= 1'b0;
        end else begin
          rx_fin_r <= 1'b0;
          case (rx_st_r)
            RX_IDLE: if (tick && !rx_line && rx_ok) begin
              rx_st_r <= RX_RUN;
              rsh_r <= 8'h00;
              // Direct clock: the detecting edge is the start sample
              ridx_r <= (nper == `DCS_DIV_1) ? 4'h1 : 4'h0;
              rdiv_r <= nper >> 1;
            end
            default: if (tick) begin
              if (rdiv_r != 7'h0)
                rdiv_r <= rdiv_r - 7'h1;
              else begin
                rdiv_r <= nper - 7'h1;
                ridx_r <= ridx_r + 4'h1;
                if (ridx_r == 4'h0) begin
                  if (rx_line) rx_st_r <= RX_IDLE;
                end else if (ridx_r <= rlen)
                  rsh_r <= {rx_line, rsh_r[7:1]};
                else if (ridx_r != rlast)
                  rpar_r <= rx_line;
                else begin
                  rstop_r <= rx_line;
                  rx_fin_r <= 1'b1;
                  rx_st_r <= RX_IDLE;
                end
              end
            end
          endcase
        end
      end

      wire [7:0] rdat = rsh_r >> (4'h8 - rlen);
      wire rpe = pen & (rpar_r != ((^rdat) ^ ~pev));
      wire rbrk = (rdat == 8'h00) & ~rstop_r & ~(pen & rpar_r);
      wire r_push = rx_fin_r & ~rbrk;
      wire r_fe = rx_fin_r & ~rbrk & ~rstop_r;
      // R24: overrun when queue already holds three characters
      wire r_ov = r_push & ~rx_rdy;
      wire r_pe = r_push & rpe;

      // Receive char_queue; a new char on a full queue is dropped
      dcs_fifo #(.WIDTH(8), .DEPTH(`DCS_RXQ_DEPTH), .AW(`DCS_RXQ_AW)) u_rxq (
        .clock(clock),
        .resetn(resetn),
        .flush(chan_rst),
        .in_valid(r_push),
        .in_data(rdat),
        .in_ready(rx_rdy),
        .out_valid(rx_av),
        .out_data(rx_head),
        .out_ready(dat_rd)
      );

      // R7: error bits latch; a new error beats the reset
      always @(posedge clock) begin
        if (!resetn || chan_rst)
          err_r <= 3'h0;
        else
          err_r <= (err_rst ? 3'h0 : err_r) | {r_fe, r_ov, r_pe};
      end

      // Break holds until the line returns to mark
      always @(posedge clock) begin
        if (!resetn || chan_rst)
          brk_live_r <= 1'b0;
        else if (rx_fin_r && rbrk)
          brk_live_r <= 1'b1;
        else if (rx_line)
          brk_live_r <= 1'b0;
      end

      wire [2:0] live = {brk_live_r, cts_on, dcd_on};
      wire [2:0] chg = live ^ ref_r;
      wire echg = ~elat_r & (chg != 3'h0);
      wire [2:0] first = chg[2] ? 3'h4 : (chg[1] ? 3'h2 : 3'h1);

      // R3: external status frozen until reset reloads it
      // R20: first changed bit in break, cts, dcd order reads one, other two read zero
      always @(posedge clock) begin
        if (!resetn) begin
          ref_r <= 3'h0;
          shown_r <= 3'h0;
          elat_r <= 1'b0;
        end else if (ext_rst || chan_rst) begin
          ref_r <= live;
          shown_r <= live;
          elat_r <= 1'b0;
        end else if (echg) begin
          shown_r <= first;
          elat_r <= 1'b1;
        end
      end

      // R9: receive interrupt per mode; R5: first-char waits rearm
      wire s_rx = r_push & ((rmode == `DCS_RXI_ALL_PAR) | (rmode == `DCS_RXI_ALL) |
        ((rmode == `DCS_RXI_FIRST) & arm_r));
      wire s_sp = (rmode != `DCS_RXI_OFF) & (r_fe | r_ov |
        (r_pe & (rmode == `DCS_RXI_ALL_PAR)));
      // R6: set when buffer drains; R11: enables
      wire s_tx = tx_av_q & ~tx_av & wr1_r[`DCS_WR1_TXIE];
      wire s_ext = echg & wr1_r[`DCS_WR1_EXTIE];
      wire [3:0] iset = {s_sp, s_rx, s_ext, s_tx};
      // R4, R6, R7 and R8: clears; reads and writes clear too
      wire [3:0] iclr = reti_clr[gi*4 +: 4] | {err_rst, dat_rd, ext_rst, txi_clr | dat_wr};

      // Pending sources; a new event beats its clear
      always @(posedge clock) begin
        if (!resetn || chan_rst) begin
          ip_r <= 4'h0;
          arm_r <= 1'b1;
          tx_av_q <= 1'b0;
        end else begin
          ip_r <= (ip_r & ~iclr) | iset;
          tx_av_q <= tx_av;
          // R5: rearm command reopens first-character capture
          if (rearm)
            arm_r <= 1'b1;
          else if (s_rx && rmode == `DCS_RXI_FIRST)
            arm_r <= 1'b0;
        end
      end

      // R21: status byte; pending bit merged at top for channel 0
      always @* begin
        rr0_c = 8'h00;
        rr0_c[`DCS_RR0_BRK] = shown_r[2];
        rr0_c[`DCS_RR0_CTS] = shown_r[1];
        rr0_c[`DCS_RR0_DCD] = shown_r[0];
        rr0_c[`DCS_RR0_TBE] = tx_rdy;
        rr0_c[`DCS_RR0_RCA] = rx_av;
      end

      assign ptr_w[gi*3 +: 3] = ptr_r;
      assign rr0_w[gi*8 +: 8] = rr0_c;
      // R22: all sent needs empty buffer and idle shifter
      assign rr1_w[gi*8 +: 8] = {1'b0, err_r, 3'h0, ~tx_av & (tx_st_r == TX_IDLE)};
      assign rxh_w[gi*8 +: 8] = rx_av ? rx_head : 8'h00;
      assign ip_w[gi*4 +: 4] = ip_r;
      assign sav_w[gi] = wr1_r[`DCS_WR1_SAV];
      assign txd[gi] = txd_r;
      assign rts_n[gi] = rts_n_r;
      assign dtr_n[gi] = dtr_n_r;
    end
  endgenerate
endmodule // dcs_serial

// ### testbench/dcs_line_model.sv
/* Terminal on the channel 0 line.
   Assumes divide-by-16 cells and 8-bit frames without parity. */
module dcs_line_model (
  // Bit clock and line from the block
  input wire logic bclk,
  input wire logic txd,
  // Lines to the block
  output logic rxd,
  output logic cts_n,
  output logic dcd_n,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  // Modem lines active, line idle high
  initial begin
    {rxd, cts_n, dcd_n, got} = {3'h4, 8'h00};
  end
  // Frame LSB first, one bit every sixteen ticks
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge bclk) rxd = f[i];
      repeat (15) @(negedge bclk);
    end
  endtask
  // Mid-cell sampling; start edge found on the line itself
  always begin
    @(negedge txd);
    repeat (8) @(posedge bclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge bclk);
      got[i] = txd;
    end
    repeat (16) @(posedge bclk);
  end
endmodule // dcs_line_model

// ### testbench/dcs_serial_sva.sv
/* Port checker for dcs_serial.
   Assumes one clock domain and a bind into the top module. */
module dcs_serial_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Host bus
  input wire logic [23:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata_r,
  // Interrupt and serial outputs
  input wire logic irq_n_r,
  input wire logic [7:0] int_vector_r,
  input wire logic [1:0] txd,
  input wire logic [1:0] rts_n,
  input wire logic [1:0] dtr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Reset values, read data hold, and modem and vector base bits moving only after a host write
  a_reset_idle: assert property ($rose(resetn) |-> irq_n_r && txd == 2'h3 &&
    dtr_n == 2'h3 && rts_n == 2'h3) else $error("outputs not idle after reset");
  a_reset_vec: assert property ($rose(resetn) |-> int_vector_r == 8'h00 &&
    bus_rdata_r == 8'h00) else $error("vector or read data not cleared");
  a_quiet_start: assert property ($rose(resetn) |-> irq_n_r [*3])
    else $error("interrupt before any enable");
  a_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata_r))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (bus_rd && (bus_addr[23:3] != 21'h184200 ||
    !bus_addr[0]) |=> bus_rdata_r == 8'h00) else $error("unmapped read not zero");
  a_dtr_by_wr: assert property ($changed(dtr_n) |-> $past(bus_wr) || $past(bus_wr, 2))
    else $error("terminal ready moved without a write");
  a_rts_by_wr: assert property ($changed(rts_n) |-> $past(bus_wr) || $past(bus_wr, 2))
    else $error("send request moved without a write");
  a_base_by_wr: assert property ($changed({int_vector_r[7:4], int_vector_r[0]}) |->
    $past(bus_wr) || $past(bus_wr, 2)) else $error("vector base bits moved");
endmodule // dcs_serial_sva

bind dcs_serial dcs_serial_sva dcs_serial_sva_inst (.clock, .resetn, .bus_addr, .bus_wr,
  .bus_rd, .bus_rdata_r, .irq_n_r, .int_vector_r, .txd, .rts_n, .dtr_n);

// ### testbench/tb_top.sv
/* Self-checking bench for dcs_serial.
   Assumes the line model on channel 0; channel 1 lines held quiet. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] c0 = 24'hc21005, c1 = 24'hc21007, d0 = 24'hc21001;
  logic clock = 1'b0, resetn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, bck = 1'b0;
  logic [23:0] bus_addr = 24'h000000;
  logic [7:0] bus_wdata = 8'h00, got;
  logic rx0, cts0, dcd0;
  wire [7:0] bus_rdata_r, int_vector_r;
  wire irq_n_r;
  wire [1:0] txd, rts_n, dtr_n;
  int mismatches = 0, total_checks = 0, cyc = 0;
  dcs_serial dcs_serial_inst (.clock, .resetn, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
    .bus_rdata_r, .irq_n_r, .int_vector_r, .bclk({bck, bck}), .rxd({1'b1, rx0}),
    .cts_n({1'b0, cts0}), .dcd_n({1'b0, dcd0}), .txd, .rts_n, .dtr_n);
  dcs_line_model dcs_line_model_inst (.bclk(bck), .txd(txd[0]), .rxd(rx0), .cts_n(cts0),
    .dcd_n(dcd0), .got);
  // System clock, and a bit clock of eight cycles
  initial forever #20 clock = ~clock;
  initial forever #160 bck = ~bck;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One-cycle strobes, driven just after an edge
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clock);
    {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    {bus_addr, bus_rd} <= {a, 1'b1};
    @(posedge clock);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata_r & m, e);
  endtask
  task automatic wreg(input logic [23:0] a, input logic [2:0] p, input logic [7:0] d);
    wr(a, {5'h00, p});
    wr(a, d);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard well above the longest path
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      give_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    wr(c0, 8'h18);
    wr(c1, 8'h18);
    wreg(c0, 3'h5, 8'h82);
    rd(c0, 8'h07, 8'h04);
    rd(c0, 8'ha8, 8'h20);
    wr(c0, 8'h10);
    rd(c0, 8'ha8, 8'h28);
    chk({6'h00, dtr_n[0], rts_n[0]}, 8'h00);
    chk({6'h00, dtr_n[1], rts_n[1]}, 8'h03);
    rd(24'hc21009, 8'hff, 8'h00);
    $display("test lines done");
    // Shared vector, then channel 0 receive at x16, 8 bits
    wreg(c1, 3'h2, 8'h40);
    wreg(c1, 3'h1, 8'h04);
    wr(c1, 8'h02);
    rd(c1, 8'hff, 8'h40);
    wreg(c0, 3'h4, 8'h40);
    wreg(c0, 3'h3, 8'hc1);
    wreg(c0, 3'h1, 8'h18);
    dcs_line_model_inst.send(8'ha5);
    repeat (20) @(posedge clock);
    chk({7'h00, irq_n_r}, 8'h00);
    chk(int_vector_r, 8'h4c);
    rd(c0, 8'h01, 8'h01);
    rd(d0, 8'hff, 8'ha5);
    repeat (3) @(posedge clock);
    chk({int_vector_r[7:1], irq_n_r}, 8'h41);
    // Fourth character overruns the three-deep queue
    for (int i = 1; i < 5; i++) dcs_line_model_inst.send(8'(i));
    repeat (20) @(posedge clock);
    wr(c0, 8'h01);
    rd(c0, 8'h70, 8'h20);
    chk(int_vector_r, 8'h4e);
    wr(c0, 8'h30);
    wr(c0, 8'h01);
    rd(c0, 8'h70, 8'h00);
    for (int i = 1; i < 4; i++) rd(d0, 8'hff, 8'(i));
    $display("test receive done");
    // Transmit one byte; all-sent only after the frame
    wreg(c0, 3'h5, 8'he8);
    wr(d0, 8'h3c);
    wr(c0, 8'h01);
    rd(c0, 8'h01, 8'h00);
    repeat (1400) @(posedge clock);
    chk(got, 8'h3c);
    wr(c0, 8'h01);
    rd(c0, 8'h01, 8'h01);
    $display("test transmit done");
    give_verdict;
  end
endmodule // tb_top
